// >>> rtl/pscs_device.sv
/*
  Device end of the passive serial configuration sequencer.
  Assumes the host drives the request and serial clock; all link inputs are
  asynchronous and pass two flops first. Pull-ups are modelled in the interface.
*/
`include "pscs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pscs_device (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Link side.
  pscs_link_if.device LINK,
  // Options and user side.
  input wire logic USE_USER_CLK_I,
  input wire logic USER_STARTUP_CLOCK_I,
  input wire logic CRC_ERROR_I,
  output logic USER_MODE_O,
  output logic [7:0] CFG_BYTE_O,
  output logic CFG_VALID_O,
  input wire logic CFG_READY_I
);
  typedef struct packed {
    logic [1:0] rq_s;
    logic [1:0] ck_s;
    logic [1:0] dt_s;
    logic [1:0] st_s;
    logic [1:0] cd_s;
    logic [1:0] uc_s;
    logic ck_prev;
    logic uc_prev;
    pscs_pkg::pscs_dev_e state;
    pscs_pkg::pscs_cnt_t cnt;
    pscs_pkg::pscs_cnt_t bits;
    logic [2:0] bitpos;
    logic [7:0] shreg;
    logic push;
    logic [1:0] falls;
    logic stat_low;
    logic done_low;
    logic ceo_n;
    logic user;
  } pscs_dev_s;
  pscs_dev_s s_q;
  pscs_dev_s s_d;
  logic fifo_ready;
  logic ck_rise;
  logic ck_fall;
  logic uc_rise;
  assign ck_rise = s_q.ck_s[1] && !s_q.ck_prev;
  assign ck_fall = !s_q.ck_s[1] && s_q.ck_prev;
  assign uc_rise = s_q.uc_s[1] && !s_q.uc_prev;
  // Next-state logic; only the second flop of each synchroniser is read.
  always_comb begin
    s_d = s_q;
    s_d.rq_s = {s_q.rq_s[0], LINK.reconfig_n};
    s_d.ck_s = {s_q.ck_s[0], LINK.serial_config_clock};
    s_d.dt_s = {s_q.dt_s[0], LINK.serial_config_bit};
    s_d.st_s = {s_q.st_s[0], LINK.status_n};
    s_d.cd_s = {s_q.cd_s[0], LINK.conf_done};
    s_d.uc_s = {s_q.uc_s[0], USER_STARTUP_CLOCK_I};
    s_d.ck_prev = s_q.ck_s[1];
    s_d.uc_prev = s_q.uc_s[1];
    s_d.push = 1'b0;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    // A request low aborts any phase but power-on at once, well inside 800 ns.
    if (!s_q.rq_s[1] && s_q.state != pscs_pkg::PSCS_DEV_POR) begin
      s_d.state = pscs_pkg::PSCS_DEV_RESET;
      s_d.stat_low = 1'b1;
      s_d.done_low = 1'b1;
      s_d.ceo_n = 1'b1;
      s_d.user = 1'b0;
      s_d.cnt = 16'(`PSCS_STATUS_CYC);
    end else begin
      unique case (s_q.state)
        pscs_pkg::PSCS_DEV_POR: begin
          s_d.stat_low = 1'b1;
          s_d.done_low = 1'b1;
          if (s_q.cnt == '0) begin
            s_d.state = pscs_pkg::PSCS_DEV_RESET;
            s_d.cnt = 16'(`PSCS_STATUS_CYC);
          end
        end
        pscs_pkg::PSCS_DEV_RESET: begin
          // Own pulse ends after the 10 us minimum once the request is high.
          if (s_q.cnt == '0) begin
            s_d.stat_low = 1'b0;
            s_d.state = pscs_pkg::PSCS_DEV_WAITST;
          end
        end
        pscs_pkg::PSCS_DEV_WAITST: begin
          s_d.bits = '0;
          s_d.bitpos = '0;
          if (s_q.st_s[1]) begin
            s_d.state = pscs_pkg::PSCS_DEV_LOAD;
          end
        end
        pscs_pkg::PSCS_DEV_LOAD: begin
          if (!s_q.st_s[1] || CRC_ERROR_I || (s_q.push && !fifo_ready)) begin
            // Error or overrun halts the whole chain through the shared line.
            s_d.stat_low = 1'b1;
            s_d.state = pscs_pkg::PSCS_DEV_RESET;
            s_d.cnt = 16'(`PSCS_STATUS_CYC);
          end else if (ck_rise) begin
            // LSB arrives first, so bits fill from the top down.
            s_d.shreg = {s_q.dt_s[1], s_q.shreg[7:1]};
            s_d.bitpos = s_q.bitpos + 1'b1;
            s_d.bits = s_q.bits + 1'b1;
            s_d.push = (s_q.bitpos == 3'h7);
            if (s_q.bits == 16'(`PSCS_IMAGE_BITS - 1)) begin
              s_d.done_low = 1'b0;
              s_d.ceo_n = 1'b0;
              s_d.falls = '0;
              s_d.state = pscs_pkg::PSCS_DEV_INIT;
              s_d.cnt = USE_USER_CLK_I ? 16'(`PSCS_CD2CU_CYC) : 16'(`PSCS_CD2UM_CYC);
            end
          end
        end
        pscs_pkg::PSCS_DEV_INIT: begin
          // Count only once the shared done line is really high.
          if (!s_q.cd_s[1]) begin
            s_d.cnt = s_q.cnt;
            s_d.falls = '0;
          end else if (s_q.falls != 2'(`PSCS_INIT_EDGES)) begin
            s_d.cnt = s_q.cnt;
            if (ck_fall) begin
              s_d.falls = s_q.falls + 1'b1;
            end
          end else if (USE_USER_CLK_I) begin
            // First wait four serial clock periods in core time, then count user clock cycles.
            // The host stops its clock after the two trailing edges, so this delay cannot
            // count serial clock edges without hanging.
            if (s_q.bits != '0) begin
              if (s_q.cnt == '0) begin
                s_d.bits = '0;
                s_d.cnt = 16'(`PSCS_USR_CYCLES);
              end
            end else begin
              s_d.cnt = uc_rise ? s_q.cnt - 1'b1 : s_q.cnt;
              if (s_q.cnt == '0) begin
                s_d.state = pscs_pkg::PSCS_DEV_USER;
              end
            end
          end else if (s_q.cnt == '0) begin
            s_d.state = pscs_pkg::PSCS_DEV_USER;
          end
        end
        pscs_pkg::PSCS_DEV_USER: begin
          s_d.user = 1'b1;
        end
        default: begin
          s_d.state = pscs_pkg::PSCS_DEV_RESET;
        end
      endcase
    end
  end
  // State register with synchronous reset into the power-on phase.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s_q <= '{rq_s: 2'h3, ck_s: 2'h0, dt_s: 2'h0, st_s: 2'h0, cd_s: 2'h0, uc_s: 2'h0,
        ck_prev: 1'b0, uc_prev: 1'b0, state: pscs_pkg::PSCS_DEV_POR,
        cnt: 16'(`PSCS_POR_CYC), bits: 16'h0000, bitpos: 3'h0, shreg: 8'h00, push: 1'b0,
        falls: 2'h0, stat_low: 1'b1, done_low: 1'b1, ceo_n: 1'b1, user: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  // Assembled bytes are buffered; a byte pushed into a full FIFO counts as an overrun error, except the last byte of the image.
  pscs_fifo #(.WIDTH(`PSCS_FIFO_W), .DEPTH(`PSCS_FIFO_D)) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(s_q.push),
    .in_ready_o(fifo_ready),
    .in_data_i(s_q.shreg),
    .out_valid_o(CFG_VALID_O),
    .out_ready_i(CFG_READY_I),
    .out_data_o(CFG_BYTE_O)
  );
  assign LINK.status_oe_dev = s_q.stat_low;
  assign LINK.done_oe_dev = s_q.done_low;
  assign LINK.chain_enable_out_n = s_q.ceo_n;
  assign USER_MODE_O = s_q.user;
endmodule
`default_nettype wire

// >>> rtl/pscs_consts.svh
/*
  Timing and size constants for the serial configuration sequencer, both ends.
  Assumes a 25 MHz core clock on each end.
*/
`ifndef PSCS_CONSTS_SVH
`define PSCS_CONSTS_SVH
`define PSCS_CLK_NS 40
// Documented times in their own unit.
`define PSCS_CF2CD_MAX_NS 800
`define PSCS_CFG_MIN_US 2
`define PSCS_STATUS_MIN_US 10
`define PSCS_STATUS_MAX_US 500
`define PSCS_CF2CK_MIN_US 500
`define PSCS_ST2CK_MIN_US 2
`define PSCS_CD2UM_MIN_US 55
`define PSCS_CD2UM_MAX_US 150
`define PSCS_CD2CU_PERIODS 4
`define PSCS_USR_CYCLES 8532
`define PSCS_INIT_EDGES 2
// Derived cycle counts: least times round up, longest round down.
`define PSCS_CF2CD_CYC (`PSCS_CF2CD_MAX_NS / `PSCS_CLK_NS)
`define PSCS_CFG_CYC ((`PSCS_CFG_MIN_US * 1000 + `PSCS_CLK_NS - 1) / `PSCS_CLK_NS)
`define PSCS_STATUS_CYC ((`PSCS_STATUS_MIN_US * 1000 + `PSCS_CLK_NS - 1) / `PSCS_CLK_NS)
`define PSCS_CF2CK_CYC ((`PSCS_CF2CK_MIN_US * 1000 + `PSCS_CLK_NS - 1) / `PSCS_CLK_NS)
`define PSCS_ST2CK_CYC ((`PSCS_ST2CK_MIN_US * 1000 + `PSCS_CLK_NS - 1) / `PSCS_CLK_NS)
`define PSCS_CD2UM_CYC ((`PSCS_CD2UM_MIN_US * 1000 + `PSCS_CLK_NS - 1) / `PSCS_CLK_NS)
// Serial clock half period of the host divider, in core cycles.
`define PSCS_HALF_CYC 4
// Start-up clock enable delay: four host serial clock periods, in core cycles.
`define PSCS_CD2CU_CYC (`PSCS_CD2CU_PERIODS * 2 * `PSCS_HALF_CYC)
// Power-on status hold, in core cycles.
`define PSCS_POR_CYC 256
// Image length in bits and FIFO geometry.
`define PSCS_IMAGE_BITS 64
`define PSCS_FIFO_W 8
`define PSCS_FIFO_D 16
`endif

// >>> rtl/pscs_pkg.sv
/*
  Types shared by both ends of the serial configuration sequencer.
  Assumes pscs_consts.svh is compiled alongside.
*/
package pscs_pkg;
  typedef logic [15:0] pscs_cnt_t;
  typedef enum logic [5:0] {
    PSCS_DEV_POR = 6'h01,
    PSCS_DEV_RESET = 6'h02,
    PSCS_DEV_WAITST = 6'h04,
    PSCS_DEV_LOAD = 6'h08,
    PSCS_DEV_INIT = 6'h10,
    PSCS_DEV_USER = 6'h20
  } pscs_dev_e;
  typedef enum logic [5:0] {
    PSCS_HST_IDLE = 6'h01,
    PSCS_HST_PULSE = 6'h02,
    PSCS_HST_WAIT = 6'h04,
    PSCS_HST_SHIFT = 6'h08,
    PSCS_HST_TAIL = 6'h10,
    PSCS_HST_DONE = 6'h20
  } pscs_hst_e;
endpackage

// >>> rtl/pscs_link_if.sv
/*
  Link between the configuration host and the device.
  Open-drain lines are resolved here: status from both ends' enables, done from the device's alone; low while any end drives.
*/
`timescale 1ns/100ps
`default_nettype none
interface pscs_link_if;
  logic reconfig_n;
  logic serial_config_clock;
  logic serial_config_bit;
  logic status_oe_dev;
  logic status_oe_ext;
  logic done_oe_dev;
  logic chain_enable_out_n;
  logic status_n;
  logic conf_done;
  // Open-drain resolution with pull-up.
  assign status_n = !(status_oe_dev || status_oe_ext);
  assign conf_done = !done_oe_dev;
  modport host (output reconfig_n, output serial_config_clock, output serial_config_bit,
    output status_oe_ext, input status_n, input conf_done);
  modport device (input reconfig_n, input serial_config_clock, input serial_config_bit,
    output status_oe_dev, output done_oe_dev, output chain_enable_out_n,
    input status_n, input conf_done);
endinterface
`default_nettype wire

// >>> rtl/pscs_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pscs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  // Extra pointer bit tells full from empty.
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rp_q[AW-1:0]];
  // Pointers advance only on an accepted handshake.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid_i && !full) begin
        mem[wp_q[AW-1:0]] <= in_data_i;
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pscs_host.sv
/*
  Host end: pulses the request, waits, then shifts image bytes LSB first.
  Assumes the serial clock it makes comes from its own core clock by a divider.
*/
`include "pscs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pscs_host (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Link side.
  pscs_link_if.host LINK,
  // User side.
  input wire logic START_I,
  input wire logic HOLD_STATUS_I,
  input wire logic [7:0] IMG_BYTE_I,
  input wire logic IMG_VALID_I,
  output logic IMG_READY_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic ERROR_O
);
  typedef struct packed {
    logic [1:0] st_s;
    logic [1:0] cd_s;
    pscs_pkg::pscs_hst_e state;
    pscs_pkg::pscs_cnt_t cnt;
    logic [2:0] half;
    logic [2:0] bitpos;
    logic [7:0] shreg;
    logic have;
    logic [1:0] tail;
    logic rq_n;
    logic sck;
    logic sdat;
    logic err;
  } pscs_hst_s;
  pscs_hst_s s_q;
  pscs_hst_s s_d;
  logic take;
  assign take = (s_q.state == pscs_pkg::PSCS_HST_SHIFT) && !s_q.have && IMG_VALID_I;
  assign IMG_READY_O = (s_q.state == pscs_pkg::PSCS_HST_SHIFT) && !s_q.have;
  // Sequencer; the divider keeps the serial clock far below the device limit.
  always_comb begin
    s_d = s_q;
    s_d.st_s = {s_q.st_s[0], LINK.status_n};
    s_d.cd_s = {s_q.cd_s[0], LINK.conf_done};
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    unique case (s_q.state)
      pscs_pkg::PSCS_HST_IDLE: begin
        if (START_I) begin
          s_d.rq_n = 1'b0;
          s_d.err = 1'b0;
          s_d.cnt = 16'(`PSCS_CFG_CYC);
          s_d.state = pscs_pkg::PSCS_HST_PULSE;
        end
      end
      pscs_pkg::PSCS_HST_PULSE: begin
        if (s_q.cnt == '0) begin
          s_d.rq_n = 1'b1;
          s_d.cnt = 16'(`PSCS_CF2CK_CYC);
          s_d.state = pscs_pkg::PSCS_HST_WAIT;
        end
      end
      pscs_pkg::PSCS_HST_WAIT: begin
        // Status low restarts the 2 us wait after it rises.
        if (!s_q.st_s[1] && s_q.cnt < 16'(`PSCS_ST2CK_CYC)) begin
          s_d.cnt = 16'(`PSCS_ST2CK_CYC);
        end else if (s_q.cnt == '0 && s_q.st_s[1]) begin
          s_d.state = pscs_pkg::PSCS_HST_SHIFT;
          s_d.half = '0;
          s_d.have = 1'b0;
        end
      end
      pscs_pkg::PSCS_HST_SHIFT: begin
        if (!s_q.st_s[1]) begin
          s_d.err = 1'b1;
          s_d.sck = 1'b0;
          s_d.state = pscs_pkg::PSCS_HST_DONE;
        end else if (s_q.cd_s[1] && !s_q.sck) begin
          s_d.tail = '0;
          s_d.half = '0;
          s_d.state = pscs_pkg::PSCS_HST_TAIL;
        end else if (take) begin
          s_d.shreg = IMG_BYTE_I;
          s_d.bitpos = '0;
          s_d.have = 1'b1;
          s_d.sdat = IMG_BYTE_I[0];
        end else if (s_q.have) begin
          s_d.half = s_q.half + 1'b1;
          if (s_q.half == 3'(`PSCS_HALF_CYC - 1)) begin
            s_d.half = '0;
            s_d.sck = !s_q.sck;
            if (s_q.sck) begin
              // Falling edge: present the next bit.
              s_d.bitpos = s_q.bitpos + 1'b1;
              s_d.sdat = s_q.shreg[3'(s_q.bitpos + 1'b1)];
              s_d.have = (s_q.bitpos != 3'h7);
            end
          end
        end
      end
      pscs_pkg::PSCS_HST_TAIL: begin
        // Two trailing falling edges start the device's initialization.
        s_d.half = s_q.half + 1'b1;
        if (s_q.half == 3'(`PSCS_HALF_CYC - 1)) begin
          s_d.half = '0;
          s_d.sck = !s_q.sck;
          if (s_q.sck) begin
            s_d.tail = s_q.tail + 1'b1;
            if (s_q.tail == 2'(`PSCS_INIT_EDGES - 1)) begin
              s_d.state = pscs_pkg::PSCS_HST_DONE;
            end
          end
        end
      end
      pscs_pkg::PSCS_HST_DONE: begin
        if (START_I) begin
          s_d.state = pscs_pkg::PSCS_HST_IDLE;
        end
      end
      default: begin
        s_d.state = pscs_pkg::PSCS_HST_IDLE;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      s_q <= '{st_s: 2'h0, cd_s: 2'h0, state: pscs_pkg::PSCS_HST_IDLE, cnt: 16'h0000,
        half: 3'h0, bitpos: 3'h0, shreg: 8'h00, have: 1'b0, tail: 2'h0, rq_n: 1'b1,
        sck: 1'b0, sdat: 1'b0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign LINK.reconfig_n = s_q.rq_n;
  assign LINK.serial_config_clock = s_q.sck;
  assign LINK.serial_config_bit = s_q.sdat;
  assign LINK.status_oe_ext = HOLD_STATUS_I;
  assign BUSY_O = (s_q.state != pscs_pkg::PSCS_HST_IDLE) && (s_q.state != pscs_pkg::PSCS_HST_DONE);
  assign DONE_O = (s_q.state == pscs_pkg::PSCS_HST_DONE) && !s_q.err;
  assign ERROR_O = s_q.err;
endmodule
`default_nettype wire

// >>> dv/pscs_link_assertions.sv
/*
  Concurrent checks on the link lines between host and device.
  Assumes the bench feeds the resolved interface lines and the core clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pscs_link_assertions (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // Link lines.
  input wire logic reconfig_n,
  input wire logic serial_config_clock,
  input wire logic status_oe_dev,
  input wire logic status_n,
  input wire logic conf_done,
  input wire logic chain_enable_out_n
);
  localparam int STATUS_MIN = 250;
  localparam int STATUS_MAX = 12500;
  logic [15:0] lo_cnt_q;
  logic [7:0] bit_cnt_q;
  logic sck_q;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Status pulse length and serial clock rises since the last request; the count saturates.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      lo_cnt_q <= 16'h0000;
      bit_cnt_q <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      lo_cnt_q <= status_oe_dev ? lo_cnt_q + 16'h0001 : 16'h0000;
      sck_q <= serial_config_clock;
      if (!reconfig_n) begin
        bit_cnt_q <= 8'h00;
      end else if (serial_config_clock && !sck_q && bit_cnt_q != 8'hff) begin
        bit_cnt_q <= bit_cnt_q + 8'h01;
      end
    end
  end
  sequence req_fall;
    $fell(reconfig_n);
  endsequence
  sequence done_up;
    $rose(conf_done);
  endsequence
  // A 800 ns bound is 20 core cycles.
  cf2cd_fast_a: assert property (req_fall |-> ##[0:20] !conf_done)
    else $error("done not low soon after request");
  cf2st_fast_a: assert property (req_fall |-> ##[0:20] status_oe_dev)
    else $error("status not pulled low soon after request");
  pulse_min_a: assert property ($fell(status_oe_dev) |-> lo_cnt_q >= STATUS_MIN)
    else $error("status pulse too short");
  pulse_max_a: assert property (status_oe_dev |-> lo_cnt_q < STATUS_MAX)
    else $error("status pulse too long");
  done_hold_a: assert property (reconfig_n && bit_cnt_q < 8'd64 |-> !conf_done)
    else $error("done high before whole image");
  done_gate_a: assert property (done_up |-> status_n && $past(status_n, 8))
    else $error("done rose while status low");
  user_lines_a: assert property (conf_done && reconfig_n && $past(reconfig_n) |-> status_n)
    else $error("status low in user mode");
  chain_pass_a: assert property (done_up |-> ##[0:8] !chain_enable_out_n)
    else $error("chain enable not passed on");
endmodule
`default_nettype wire

// >>> dv/passive_serial_config_sequencer_tb_top.sv
/*
  Self-checking bench: host and device ends joined by the link interface.
  Assumes the design files and pscs_consts.svh are compiled first.
*/
`include "pscs_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module passive_serial_config_sequencer_tb_top;
  localparam int UCLK_HALF = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic uclk = 1'b0;
  logic start = 1'b0;
  logic hold_status = 1'b0;
  logic use_user = 1'b0;
  logic crc_err = 1'b0;
  logic cfg_ready = 1'b0;
  logic img_ready, busy, done, error, user_mode, cfg_valid;
  logic [7:0] cfg_byte;
  logic [7:0] img [8] = '{8'h02, 8'h1b, 8'hee, 8'h01, 8'hfa, 8'h5a, 8'ha5, 8'h80};
  logic [7:0] got [16];
  logic [63:0] wbits;
  logic [63:0] exp_bits;
  int idx = 8;
  int nb = 0;
  int ng = 0;
  int t;
  int fail_count = 0;
  int n_tests = 0;
  pscs_link_if u_pscs_link_if ();
  pscs_host u_pscs_host (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(u_pscs_link_if), .START_I(start),
    .HOLD_STATUS_I(hold_status), .IMG_BYTE_I(img[idx[2:0]]), .IMG_VALID_I(idx < 8), .IMG_READY_O(img_ready),
    .BUSY_O(busy), .DONE_O(done), .ERROR_O(error));
  pscs_device u_pscs_device (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(u_pscs_link_if), .USE_USER_CLK_I(use_user),
    .USER_STARTUP_CLOCK_I(uclk), .CRC_ERROR_I(crc_err), .USER_MODE_O(user_mode), .CFG_BYTE_O(cfg_byte),
    .CFG_VALID_O(cfg_valid), .CFG_READY_I(cfg_ready));
  pscs_link_assertions u_pscs_link_assertions (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .reconfig_n(u_pscs_link_if.reconfig_n), .serial_config_clock(u_pscs_link_if.serial_config_clock),
    .status_oe_dev(u_pscs_link_if.status_oe_dev), .status_n(u_pscs_link_if.status_n),
    .conf_done(u_pscs_link_if.conf_done), .chain_enable_out_n(u_pscs_link_if.chain_enable_out_n));
  // Core clock at 25 MHz; the user start-up clock runs free and out of phase with it.
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #7;
    forever #(UCLK_HALF) uclk = ~uclk;
  end
  // The byte index moves only on an accepted byte, one small delay after the edge.
  always @(posedge clk) begin
    if (idx < 8 && img_ready === 1'b1) idx <= #1 idx + 1;
  end
  // Watch the wire: bits land at the top, so the first bit sent ends up in bit 0.
  always @(posedge u_pscs_link_if.serial_config_clock) begin
    wbits = {u_pscs_link_if.serial_config_bit, wbits[63:1]};
    nb++;
  end
  // Collect what the device hands to its consumer.
  always @(posedge clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1 && ng < 16) begin
      got[ng] = cfg_byte;
      ng++;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic sel(input int which);
    case (which)
      0: sel = u_pscs_link_if.conf_done;
      1: sel = user_mode;
      2: sel = error;
      3: sel = u_pscs_link_if.status_n;
      default: sel = (nb >= 20);
    endcase
  endfunction
  // Bounded wait; running out counts as a mismatch and ends the run.
  task automatic wait_for(input int which, input int limit, output int took);
    took = 0;
    while (sel(which) !== 1'b1) begin
      if (took == limit) begin
        fail_count++;
        $display("MISMATCH at %0t: wait %0d timed out", $time, which);
        test_done();
      end
      cyc(1);
      took++;
    end
  endtask
  // From the finished state one start returns the host to idle, so some runs need two.
  task automatic begin_cfg(input int starts);
    idx = 0;
    nb = 0;
    ng = 0;
    repeat (starts) begin
      start = 1'b1;
      cyc(1);
      start = 1'b0;
      cyc(2);
    end
  endtask
  // Tests: power-on, plain load with a stalled consumer, postponed load with user clock, error, restart.
  initial begin
    for (int i = 0; i < 8; i++) exp_bits[i*8 +: 8] = img[i];
    cyc(3);
    rst = 1'b0;
    cyc(200);
    check(u_pscs_link_if.status_n, 1'b0, "status in power-on");
    check(u_pscs_link_if.conf_done, 1'b0, "done in power-on");
    wait_for(3, 1000, t);
    check(200 + t >= `PSCS_POR_CYC, 1'b1, "power-on length");
    $display("test power_on done");
    begin_cfg(1);
    wait_for(0, 20000, t);
    check(nb, 64, "bits before done");
    check(wbits, exp_bits, "wire order");
    check(ng, 0, "stalled consumer");
    cfg_ready = 1'b1;
    wait_for(1, 5000, t);
    check(t + 1 >= `PSCS_CD2UM_CYC && t <= `PSCS_CD2UM_MAX_US * 1000 / `PSCS_CLK_NS, 1'b1, "init time");
    check(ng, 8, "bytes drained");
    for (int i = 0; i < 8; i++) check(got[i], img[i], "byte");
    check(cfg_valid, 1'b0, "buffer empty");
    check({u_pscs_link_if.reconfig_n, u_pscs_link_if.status_n, u_pscs_link_if.conf_done}, 3'h7, "user lines");
    check(u_pscs_link_if.chain_enable_out_n, 1'b0, "chain enable");
    check(done, 1'b1, "host done");
    $display("test plain_load done");
    use_user = 1'b1;
    begin_cfg(2);
    // Hold only once the request is low; a held line in user mode breaks the user-mode levels.
    hold_status = 1'b1;
    cyc(60);
    check({user_mode, u_pscs_link_if.conf_done}, 2'h0, "request leaves user mode");
    cyc(14000);
    check(nb, 0, "clock while held");
    check({u_pscs_link_if.status_n, u_pscs_link_if.conf_done}, 2'h0, "held status");
    hold_status = 1'b0;
    wait_for(0, 3000, t);
    check(wbits, exp_bits, "wire order again");
    wait_for(1, 30000, t);
    check(t >= `PSCS_CD2CU_CYC + `PSCS_USR_CYCLES * 2 * UCLK_HALF / `PSCS_CLK_NS, 1'b1, "user clock init");
    check(ng, 8, "bytes again");
    $display("test user_clock done");
    use_user = 1'b0;
    begin_cfg(2);
    wait_for(4, 20000, t);
    crc_err = 1'b1;
    cyc(2);
    crc_err = 1'b0;
    wait_for(2, 400, t);
    check(u_pscs_link_if.status_n, 1'b0, "status on error");
    cyc(400);
    check(u_pscs_link_if.conf_done, 1'b0, "done after error");
    check(nb < 64, 1'b1, "load halted");
    $display("test error done");
    begin_cfg(2);
    wait_for(1, 20000, t);
    check(ng, 8, "bytes after restart");
    check(error, 1'b0, "error cleared");
    $display("test restart done");
    test_done();
  end
endmodule
`default_nettype wire
